//--- core/ebu_mux.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - select3 nand enable turns on nand logic for 0x4000_0000..0x4fff_ffff window.
// - with cs3 active and nand on, static strobes copy to nand strobes.
// - nand strobes drop at once when address leaves cs3 window.
// - nand read shares ready-in pin, nand write shares address-advance pin.
// - shared ready/read pad is input for burst flash, output for nand.
// - nand latch enables come from address bits 22 (ale) and 21 (cle).
// - csa bit 0 routes cs0 to static (0) or burst flash (1).
// - csa bit 1 routes cs1 to static (0) or sdram (1).
// - csa bit 3 keeps cs3 static and adds nand logic when set.
// - csa bit 4 enables card logic on cs4; otherwise cs4..6 static.
// - cfg bit 0 set disables pull-ups on data lines 15..0.
// - pull-ups enabled after reset since cfg resets to zero.
module ebu_mux
	import ebu_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic [31:0] xfer_addr_i,
	input  wire logic        cs3_active_i,
	input  wire ebu_strobe_s smc_strobe_i,
	input  wire logic        bfc_addr_advance_i,
	output logic             bfc_ready_o,
	input  wire logic        shared_rdy_pad_i,
	output logic             shared_rdy_pad_o,
	output logic             shared_rdy_pad_oe_o,
	output logic             shared_adv_pad_o,
	output logic             nand_ale_o,
	output logic             nand_cle_o,
	output logic             cs0_to_bfc_o,
	output logic             cs1_to_sdram_o,
	output logic             cs3_nand_on_o,
	output logic             cs4_card_on_o,
	output logic             low_data_pullup_off_o
);
	logic        [31:0] csa_r;
	logic        [31:0] csa_nxt;
	logic        [31:0] cfg_r;
	logic        [31:0] cfg_nxt;
	logic        [31:0] prdata_r;
	logic        [31:0] prdata_nxt;
	logic               access;
	logic               hit;
	ebu_assign_s        asg;
	ebu_strobe_s        nand_strobe;
	logic               in_window;

	assign access = psel_i && penable_i;
	assign hit    = (paddr_i == EBU_OFS_CSA) || (paddr_i == EBU_OFS_CFG);

	// zero-wait slave; unmapped offsets read zero and flag an error
	always_comb
	begin
		csa_nxt     = csa_r;
		cfg_nxt     = cfg_r;
		prdata_nxt  = prdata_r;
		if (access)
		begin
			if (pwrite_i)
			begin
				if (paddr_i == EBU_OFS_CSA)
					csa_nxt = pwdata_i & EBU_CSA_MASK;
				if (paddr_i == EBU_OFS_CFG)
					cfg_nxt = pwdata_i & EBU_CFG_MASK;
			end
		end
		else if (psel_i && !pwrite_i)
		begin
			unique case (paddr_i)
				EBU_OFS_CSA: prdata_nxt = csa_r;
				EBU_OFS_CFG: prdata_nxt = cfg_r;
				default:     prdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			csa_r     <= EBU_CSA_RESET;
			cfg_r     <= EBU_CFG_RESET;
			prdata_r  <= 32'h0000_0000;
		end
		else
		begin
			csa_r     <= csa_nxt;
			cfg_r     <= cfg_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	// read data is latched in setup so it is registered during access
	assign prdata_o  = prdata_r;
	assign pready_o  = 1'b1;
	assign pslverr_o = access && !hit;

	assign asg.select0_owner       = csa_r[EBU_BIT_SEL0];
	assign asg.select1_owner       = csa_r[EBU_BIT_SEL1];
	assign asg.select3_nand_enable = csa_r[EBU_BIT_SEL3];
	assign asg.select4_card_enable = csa_r[EBU_BIT_SEL4];

	assign cs0_to_bfc_o          = asg.select0_owner;
	assign cs1_to_sdram_o        = asg.select1_owner;
	assign cs3_nand_on_o         = asg.select3_nand_enable;
	assign cs4_card_on_o         = asg.select4_card_enable;
	assign low_data_pullup_off_o = cfg_r[EBU_BIT_PULLUP];

	// combinational so strobes drop the same cycle the address leaves
	assign in_window = (xfer_addr_i >= EBU_CS3_BASE) && (xfer_addr_i <= EBU_CS3_LAST);
	always_comb
	begin
		nand_strobe = '1;
		if (asg.select3_nand_enable && cs3_active_i && in_window)
			nand_strobe = smc_strobe_i;
	end

	// pad sharing: burst flash gets no ready and no advance pad while nand mode is on
	assign shared_rdy_pad_oe_o = asg.select3_nand_enable;
	assign shared_rdy_pad_o    = asg.select3_nand_enable ? nand_strobe.rd_n : 1'b1;
	assign bfc_ready_o         = asg.select3_nand_enable ? 1'b0 : shared_rdy_pad_i;
	assign shared_adv_pad_o    = asg.select3_nand_enable ? nand_strobe.wr_n
	                                                     : bfc_addr_advance_i;
	assign nand_ale_o = xfer_addr_i[EBU_ALE_BIT];
	assign nand_cle_o = xfer_addr_i[EBU_CLE_BIT];

	a_nand_read_copy: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && cs3_active_i && in_window)
		|-> shared_rdy_pad_o == smc_strobe_i.rd_n) else $error("nand read strobe not copied");
	a_nand_write_copy: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && cs3_active_i && in_window)
		|-> shared_adv_pad_o == smc_strobe_i.wr_n) else $error("nand write strobe not copied");
	a_outside_idle: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && !in_window)
		|-> shared_rdy_pad_o && shared_adv_pad_o) else $error("strobe active outside window");
	a_bfc_adv_pass: assert property (@(posedge clk_i) disable iff (reset_i)
		!asg.select3_nand_enable |-> shared_adv_pad_o == bfc_addr_advance_i)
		else $error("advance not passed");
	a_pad_dir: assert property (@(posedge clk_i) disable iff (reset_i)
		shared_rdy_pad_oe_o == csa_r[EBU_BIT_SEL3]) else $error("pad direction wrong");
	a_csa_write: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && paddr_i == EBU_OFS_CSA) |=>
		csa_r == ($past(pwdata_i) & EBU_CSA_MASK)) else $error("csa write lost");
	a_cfg_pullup: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && paddr_i == EBU_OFS_CFG) |=>
		low_data_pullup_off_o == $past(pwdata_i[0])) else $error("pullup bit wrong");
	a_reset_pullup: assert property (@(posedge clk_i)
		reset_i |=> !low_data_pullup_off_o) else $error("pullup off after reset");
	a_sel_routes: assert property (@(posedge clk_i) disable iff (reset_i)
		cs0_to_bfc_o == csa_r[0] && cs1_to_sdram_o == csa_r[1] && cs4_card_on_o == csa_r[4])
		else $error("select routing wrong");
	a_latch_bits: assert property (@(posedge clk_i) disable iff (reset_i)
		nand_ale_o == xfer_addr_i[22] && nand_cle_o == xfer_addr_i[21])
		else $error("latch enables wrong");
	a_read_back: assert property (@(posedge clk_i) disable iff (reset_i)
		(psel_i && !penable_i && !pwrite_i && paddr_i == EBU_OFS_CFG) |=>
		prdata_o == $past(cfg_r)) else $error("readback wrong");

	a_ready_tied: assert property (@(posedge clk_i) disable iff (reset_i)
		access
		|-> pready_o)
		else $error("ready low in access");

	a_err_flag: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && !hit)
		|-> pslverr_o)
		else $error("unmapped access not flagged");

	a_err_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
		(!access || hit)
		|-> !pslverr_o)
		else $error("error flag without cause");

	a_cfg_write: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && paddr_i == EBU_OFS_CFG)
		|=> cfg_r == ($past(pwdata_i) & EBU_CFG_MASK))
		else $error("cfg write lost");

	a_csa_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		!(access && pwrite_i && paddr_i == EBU_OFS_CSA)
		|=> $stable(csa_r))
		else $error("csa changed without write");

	a_cfg_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		!(access && pwrite_i && paddr_i == EBU_OFS_CFG)
		|=> $stable(cfg_r))
		else $error("cfg changed without write");

	a_bad_write: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && !hit)
		|=> $stable(csa_r) && $stable(cfg_r))
		else $error("unmapped write landed");

	a_read_csa: assert property (@(posedge clk_i) disable iff (reset_i)
		(psel_i && !penable_i && !pwrite_i && paddr_i == EBU_OFS_CSA)
		|=> prdata_o == $past(csa_r))
		else $error("csa readback wrong");

	a_read_bad: assert property (@(posedge clk_i) disable iff (reset_i)
		(psel_i && !penable_i && !pwrite_i && !hit)
		|=> prdata_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	a_read_hold: assert property (@(posedge clk_i) disable iff (reset_i)
		!(psel_i && !penable_i && !pwrite_i)
		|=> $stable(prdata_o))
		else $error("read data moved outside setup");

	a_csa_unused: assert property (@(posedge clk_i) disable iff (reset_i)
		1'b1
		|-> (csa_r & ~EBU_CSA_MASK) == 32'h0000_0000)
		else $error("csa unused bit set");

	a_cfg_unused: assert property (@(posedge clk_i) disable iff (reset_i)
		1'b1
		|-> (cfg_r & ~EBU_CFG_MASK) == 32'h0000_0000)
		else $error("cfg unused bit set");

	a_reset_routes: assert property (@(posedge clk_i)
		reset_i
		|=> !cs0_to_bfc_o && !cs1_to_sdram_o && !cs3_nand_on_o && !cs4_card_on_o)
		else $error("routes not cleared by reset");

	a_reset_pads: assert property (@(posedge clk_i)
		reset_i
		|=> !shared_rdy_pad_oe_o && shared_rdy_pad_o)
		else $error("pad not in burst mode after reset");

	a_reset_read: assert property (@(posedge clk_i)
		reset_i
		|=> prdata_o == 32'h0000_0000)
		else $error("read data not cleared by reset");

	a_cs0_write: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && paddr_i == EBU_OFS_CSA)
		|=> cs0_to_bfc_o == $past(pwdata_i[EBU_BIT_SEL0]))
		else $error("cs0 owner not taken");

	a_cs1_write: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && paddr_i == EBU_OFS_CSA)
		|=> cs1_to_sdram_o == $past(pwdata_i[EBU_BIT_SEL1]))
		else $error("cs1 owner not taken");

	a_cs3_write: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && paddr_i == EBU_OFS_CSA)
		|=> cs3_nand_on_o == $past(pwdata_i[EBU_BIT_SEL3]))
		else $error("cs3 nand enable not taken");

	a_cs4_write: assert property (@(posedge clk_i) disable iff (reset_i)
		(access && pwrite_i && paddr_i == EBU_OFS_CSA)
		|=> cs4_card_on_o == $past(pwdata_i[EBU_BIT_SEL4]))
		else $error("cs4 card enable not taken");

	a_burst_pad: assert property (@(posedge clk_i) disable iff (reset_i)
		!asg.select3_nand_enable
		|-> shared_rdy_pad_o && !shared_rdy_pad_oe_o)
		else $error("ready pad driven in burst mode");

	a_bfc_ready: assert property (@(posedge clk_i) disable iff (reset_i)
		!asg.select3_nand_enable
		|-> bfc_ready_o == shared_rdy_pad_i)
		else $error("ready not passed to burst ctrl");

	a_bfc_blocked: assert property (@(posedge clk_i) disable iff (reset_i)
		asg.select3_nand_enable
		|-> !bfc_ready_o)
		else $error("ready seen in nand mode");

	a_cs3_idle: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && !cs3_active_i)
		|-> shared_rdy_pad_o && shared_adv_pad_o)
		else $error("strobe active without cs3");

	a_strobe_source: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && (!shared_rdy_pad_o || !shared_adv_pad_o))
		|-> cs3_active_i && in_window)
		else $error("strobe active off window");

	a_read_idle: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && smc_strobe_i.rd_n)
		|-> shared_rdy_pad_o)
		else $error("read strobe without source");

	a_write_idle: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && smc_strobe_i.wr_n)
		|-> shared_adv_pad_o)
		else $error("write strobe without source");

	a_window_base: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && cs3_active_i && xfer_addr_i == EBU_CS3_BASE)
		|-> shared_adv_pad_o == smc_strobe_i.wr_n)
		else $error("window base not served");

	a_window_last: assert property (@(posedge clk_i) disable iff (reset_i)
		(asg.select3_nand_enable && cs3_active_i && xfer_addr_i == EBU_CS3_LAST)
		|-> shared_adv_pad_o == smc_strobe_i.wr_n)
		else $error("window top not served");

	c_nand_read: cover property (@(posedge clk_i) disable iff (reset_i)
		asg.select3_nand_enable && cs3_active_i && in_window && !smc_strobe_i.rd_n);
	c_nand_write: cover property (@(posedge clk_i) disable iff (reset_i)
		asg.select3_nand_enable && cs3_active_i && in_window && !smc_strobe_i.wr_n);
	c_card_on: cover property (@(posedge clk_i) disable iff (reset_i) cs4_card_on_o);
	c_bad_addr: cover property (@(posedge clk_i) disable iff (reset_i) pslverr_o);
	c_burst_ready: cover property (@(posedge clk_i) disable iff (reset_i)
		!asg.select3_nand_enable && shared_rdy_pad_i);
endmodule // ebu_mux

//--- core/ebu_pkg.sv
package ebu_pkg;
	localparam logic [11:0] EBU_OFS_CSA         = 12'h000;
	localparam logic [11:0] EBU_OFS_CFG         = 12'h004;
	localparam int          EBU_BIT_SEL0        = 0;
	localparam int          EBU_BIT_SEL1        = 1;
	localparam int          EBU_BIT_SEL3        = 3;
	localparam int          EBU_BIT_SEL4        = 4;
	localparam int          EBU_BIT_PULLUP      = 0;
	localparam logic [31:0] EBU_CSA_RESET       = 32'h0000_0000;
	localparam logic [31:0] EBU_CFG_RESET       = 32'h0000_0000;
	localparam logic [31:0] EBU_CSA_MASK        = 32'h0000_001b;
	localparam logic [31:0] EBU_CFG_MASK        = 32'h0000_0001;
	localparam logic [31:0] EBU_CS3_BASE        = 32'h4000_0000;
	localparam logic [31:0] EBU_CS3_LAST        = 32'h4fff_ffff;
	localparam int          EBU_ALE_BIT         = 22;
	localparam int          EBU_CLE_BIT         = 21;

	typedef struct packed {
		logic select4_card_enable;
		logic select3_nand_enable;
		logic select1_owner;
		logic select0_owner;
	} ebu_assign_s;

	// active-low strobes from the static controller
	typedef struct packed {
		logic rd_n;
		logic wr_n;
	} ebu_strobe_s;
endpackage

//--- tb/ebu_nand_model.sv
`timescale 1ns/1ps
module ebu_nand_model
(
	input  wire logic       we_n_i,
	input  wire logic       ale_i,
	input  wire logic       cle_i,
	output logic      [1:0] kind_o
);
	// chip enable sits on a gpio held low, so the part never idles to standby
	logic ce_n;
	assign ce_n = 1'b0;
	initial kind_o = 2'b00;
	// the host picks the window address, so the latch levels say what the word is
	always @(posedge we_n_i)
		if (!ce_n)
			kind_o <= {ale_i, cle_i};
endmodule // ebu_nand_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import ebu_pkg::*;
;
	logic        clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err;
	logic [11:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, xfer_addr_i, q;
	logic        cs3_active_i, bfc_addr_advance_i, bfc_ready_o, shared_rdy_pad_i, rdy_drv;
	logic        shared_rdy_pad_o, shared_rdy_pad_oe_o, shared_adv_pad_o, nand_ale_o, nand_cle_o;
	logic        cs0_to_bfc_o, cs1_to_sdram_o, cs3_nand_on_o, cs4_card_on_o, low_data_pullup_off_o;
	logic [1:0]  kind;
	ebu_strobe_s smc_strobe_i;
	int          n_mismatch = 0, check_count = 0, cycles = 0;
	logic [31:0] sel_val [4] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0008, 32'h0000_0010};
	assign shared_rdy_pad_i = shared_rdy_pad_oe_o ? shared_rdy_pad_o : rdy_drv;
	ebu_mux ebu_mux_inst
	(
		.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .xfer_addr_i, .cs3_active_i, .smc_strobe_i, .bfc_addr_advance_i,
		.bfc_ready_o, .shared_rdy_pad_i, .shared_rdy_pad_o, .shared_rdy_pad_oe_o,
		.shared_adv_pad_o, .nand_ale_o, .nand_cle_o, .cs0_to_bfc_o, .cs1_to_sdram_o,
		.cs3_nand_on_o, .cs4_card_on_o, .low_data_pullup_off_o
	);
	ebu_nand_model ebu_nand_model_inst
	(
		.we_n_i(shared_adv_pad_o), .ale_i(nand_ale_o), .cle_i(nand_cle_o), .kind_o(kind)
	);
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic test_done();
		if (n_mismatch == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk_i)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// released one edge early so back-to-back calls never drive psel twice in a step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do
			@(posedge clk_i);
		while (pready_o !== 1'b1);
		q = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, q, e);
	endtask
	task automatic pin(input logic [31:0] a, input logic cs, input ebu_strobe_s s);
		xfer_addr_i <= a;
		cs3_active_i <= cs;
		smc_strobe_i <= s;
		@(posedge clk_i);
	endtask
	initial
	begin
		{psel_i, penable_i, pwrite_i, cs3_active_i, bfc_addr_advance_i, rdy_drv} = 6'h00;
		{paddr_i, pwdata_i, xfer_addr_i} = 76'h0;
		smc_strobe_i = 2'b11;
		reset_i = 1'b1;
		repeat (4) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		rd(EBU_OFS_CSA, 32'h0000_0000, "csa reset");
		rd(EBU_OFS_CFG, 32'h0000_0000, "cfg reset");
		chk("pullup reset", {31'h0, low_data_pullup_off_o}, 32'h0000_0000);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b1, EBU_OFS_CSA, sel_val[i]);
			rd(EBU_OFS_CSA, sel_val[i], "csa field");
			chk("routing", {28'h0, cs4_card_on_o, cs3_nand_on_o, cs1_to_sdram_o, cs0_to_bfc_o},
				32'h1 << i);
		end
		apb(1'b1, EBU_OFS_CSA, 32'hffff_ffff);
		rd(EBU_OFS_CSA, 32'h0000_001b, "csa mask");
		apb(1'b1, EBU_OFS_CFG, 32'hffff_ffff);
		rd(EBU_OFS_CFG, 32'h0000_0001, "cfg mask");
		chk("pullup off", {31'h0, low_data_pullup_off_o}, 32'h0000_0001);
		apb(1'b1, 12'h008, 32'hffff_ffff);
		chk("unmapped err", {31'h0, err}, 32'h0000_0001);
		rd(12'h008, 32'h0000_0000, "unmapped read");
		pin(32'h4040_0000, 1'b1, 2'b10);
		chk("nand write", {shared_rdy_pad_oe_o, shared_rdy_pad_o, shared_adv_pad_o, nand_ale_o,
			nand_cle_o}, 32'h0000_001a);
		pin(32'h4040_0000, 1'b1, 2'b11);
		pin(32'h4000_0000, 1'b1, 2'b01);
		chk("latched kind", kind, 32'h0000_0002);
		chk("nand read", {shared_rdy_pad_o, shared_adv_pad_o}, 32'h0000_0001);
		pin(32'h4020_0000, 1'b1, 2'b10);
		chk("cle write", {nand_ale_o, nand_cle_o, shared_adv_pad_o}, 32'h0000_0002);
		pin(32'h4020_0000, 1'b1, 2'b11);
		pin(32'h4fff_ffff, 1'b0, 2'b00);
		chk("latched cmd", kind, 32'h0000_0001);
		chk("cs3 idle", {shared_rdy_pad_o, shared_adv_pad_o}, 32'h0000_0003);
		pin(32'h4fff_ffff, 1'b1, 2'b10);
		chk("window top", {shared_rdy_pad_o, shared_adv_pad_o}, 32'h0000_0002);
		pin(32'h3fff_ffff, 1'b1, 2'b00);
		chk("below window", {shared_rdy_pad_o, shared_adv_pad_o}, 32'h0000_0003);
		pin(32'h5000_0000, 1'b1, 2'b00); // address above the cs3 window, so both nand strobes stay high
		chk("off window", {shared_rdy_pad_o, shared_adv_pad_o}, 32'h0000_0003);
		apb(1'b1, EBU_OFS_CSA, 32'h0000_0000);
		for (int v = 0; v < 2; v++)
		begin
			bfc_addr_advance_i <= v[0];
			rdy_drv <= ~v[0];
			pin(32'h4000_0000, 1'b1, 2'b00);
			chk("burst pads", {shared_rdy_pad_oe_o, shared_adv_pad_o, bfc_ready_o},
				{30'h0, v[0], ~v[0]});
		end
		test_done();
	end
endmodule // tb_top
